/* File: include/ovph_defines.vh */
// Constants for the overflux (volts-per-hertz) protection block.
// Included by the protection block and the bench; holds definitions only.
`ifndef OVPH_DEFINES_VH
`define OVPH_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OVPH_REG_CTRL      8'h00
`define OVPH_REG_PICKUP    8'h04
`define OVPH_REG_TMS       8'h08
`define OVPH_REG_MIN_DLY   8'h0c
`define OVPH_REG_MAX_DLY   8'h10
`define OVPH_REG_COOL      8'h14
`define OVPH_REG_SCALE     8'h18
`define OVPH_REG_STATUS    8'h1c
`define OVPH_REG_FLUX_PCT  8'h20
`define OVPH_REG_IRQ_STAT  8'h24
`define OVPH_REG_IRQ_MASK  8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OVPH_ST_START      0
`define OVPH_ST_TRIP       1
`define OVPH_ST_BLOCKED    2
`define OVPH_ST_PEAKS      3
`define OVPH_IRQ_START     0
`define OVPH_IRQ_TRIP      1

// ----------------------------------------------------------------
// Modes
// ----------------------------------------------------------------
`define OVPH_MODE_OFF      2'h0
`define OVPH_MODE_DEF      2'h1
`define OVPH_MODE_INV      2'h2

// ----------------------------------------------------------------
// Reset values (delays in 0.01 s ticks)
// ----------------------------------------------------------------
`define OVPH_MODE_RST      2'h1
`define OVPH_PICKUP_RST    8'h6e
`define OVPH_TMS_RST       8'h0a
`define OVPH_MIN_DLY_RST   20'h003e8
`define OVPH_MAX_DLY_RST   20'h493e0
`define OVPH_COOL_RST      20'h186a0
`define OVPH_SCALE_RST     16'h0100

// ----------------------------------------------------------------
// Timing and characteristic figures
// ----------------------------------------------------------------
// 0.01 s of 4 ns clocks
`define OVPH_TICK_CYCLES   32'h002625a0
// 0.18 s expressed in 0.01 s ticks
`define OVPH_INV_CONST     8'h12
// Drop-off at 95 % of pick-up
`define OVPH_DROP_NUM      8'h5f
`define OVPH_DROP_DEN      8'h64

`endif

/* File: src/ovph_flux_calc.v */
// Flux integrator and peak-to-peak magnitude finder.
// Assumes samples arrive on the block clock with a one-cycle strobe.
`timescale 1ns/10ps
`default_nettype none

module ovph_flux_calc #(
  parameter SW = 16,                       // Sample width
  parameter FW = 32                        // Flux accumulator width
) (
  input  wire          sys_clk_i,          // Block clock
  input  wire          resetn_i,           // Sync reset, active low
  input  wire          clear_i,            // Drop peak state
  input  wire          sample_valid_i,     // One-cycle sample strobe
  input  wire [SW-1:0] sample_i,           // Signed line voltage sample
  output reg  [FW-1:0] flux_magnitude_o,   // Half peak-to-peak flux
  output reg           mag_valid_o         // Both peaks seen
);

  reg signed [FW-1:0] flux_r;
  reg signed [FW-1:0] pos_peak_r;
  reg signed [FW-1:0] neg_peak_r;
  reg                 rising_r;
  reg                 seen_pos_r;
  reg                 seen_neg_r;

  wire signed [FW-1:0] flux_nxt;
  wire signed [FW-1:0] span;

  assign flux_nxt = flux_r + {{(FW-SW){sample_i[SW-1]}}, sample_i};
  assign span     = pos_peak_r - neg_peak_r;

  // ----------------------------------------------------------------
  // Integration and peak search
  // ----------------------------------------------------------------
  // (RULE1) running integral
  // No DC removal: a steady offset lets the integral wander, but the
  // peak-to-peak span is unaffected as long as the swing stays in range.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flux_r     <= {FW{1'b0}};
      pos_peak_r <= {FW{1'b0}};
      neg_peak_r <= {FW{1'b0}};
      rising_r   <= 1'b1;
      seen_pos_r <= 1'b0;
      seen_neg_r <= 1'b0;
    end else if (clear_i) begin
      flux_r     <= {FW{1'b0}};
      rising_r   <= 1'b1;
      seen_pos_r <= 1'b0;
      seen_neg_r <= 1'b0;
    // (RULE17) strobed samples only
    end else if (sample_valid_i) begin
      flux_r <= flux_nxt;
      // (RULE12) positive peak
      if (rising_r && (flux_nxt < flux_r)) begin
        pos_peak_r <= flux_r;
        seen_pos_r <= 1'b1;
        rising_r   <= 1'b0;
      // (RULE12) negative peak
      end else if (!rising_r && (flux_nxt > flux_r)) begin
        neg_peak_r <= flux_r;
        seen_neg_r <= 1'b1;
        rising_r   <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Magnitude
  // ----------------------------------------------------------------
  // (RULE12) valid after both peaks
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flux_magnitude_o <= {FW{1'b0}};
      mag_valid_o      <= 1'b0;
    end else begin
      flux_magnitude_o <= (seen_pos_r && seen_neg_r && !span[FW-1]) ?
                          {1'b0, span[FW-1:1]} : {FW{1'b0}};
      mag_valid_o      <= seen_pos_r && seen_neg_r && !clear_i;
    end
  end

endmodule // ovph_flux_calc

`default_nettype wire

/* File: src/ovph_protect.v */
// Overflux (volts-per-hertz) protection: flux per-unit, definite or
// inverse square-law timing, start/trip outputs, register port, irq.
// Assumes samples and register strobes on sys_clk_i; block input is
// asynchronous and is synchronised here.
//
// Notes on behaviour
// (RULE1) Integrate every strobed sample into flux; derive flux magnitude.
// (RULE2) Characteristic computes operate delay from magnitude, mode, settings.
// (RULE3) Decision combines start, expired delay and blocking into trip.
// (RULE4) Start output while picked up; separate trip output.
// (RULE5) Blocking input disables function: no start, no trip.
// (RULE6) Modes off, definite, inverse; reset into definite.
// (RULE7) Pick-up percent in 1 % steps, default 110 %.
// (RULE8) Integer time multiplier used in inverse mode, default 10.
// (RULE9) Minimum delay: definite delay, inverse lower bound; default 10 s.
// (RULE10) Inverse delay capped at maximum delay, default 3000 s.
// (RULE11) Cooling time, default 1000 s, sets inverse reset decay.
// (RULE12) Magnitude only after both peaks; start above pick-up.
// (RULE13) Inverse delay 0.18*TMS over squared margin, clamped min/max.
// (RULE14) Below 95 % pick-up accumulator decays linearly over cooling time.
// (RULE15) Start raised first; trip only once delay expired.
// (RULE16) Disabled or blocked: outputs low, accumulators and peaks cleared.
// (RULE17) Advance only on sample strobes or the 0.01 s tick; the inverse decay steps progress_r down on the clocks that follow a tick.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ovph_defines.vh"

module ovph_protect #(
  parameter        SW          = 16,              // Sample width
  parameter [31:0] TICK_CYCLES = `OVPH_TICK_CYCLES // Clocks per 0.01 s
) (
  input  wire          sys_clk_i,          // 250 MHz clock
  input  wire          resetn_i,           // Sync reset, active low
  input  wire          sample_valid_i,     // Sample strobe
  input  wire [SW-1:0] line_voltage_samples_i, // Signed sample
  input  wire          function_block_in_i,    // User block, async
  input  wire [7:0]    reg_addr_i,         // Register byte address
  input  wire [31:0]   reg_wdata_i,        // Write data
  input  wire          reg_wr_i,           // Write strobe
  input  wire          reg_rd_i,           // Read strobe
  output reg  [31:0]   reg_rdata_o,        // Read data, next cycle
  output reg           general_start_out_o, // Start warning
  output reg           general_trip_out_o,  // Trip command
  output wire          irq_o               // Level interrupt
);

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  reg  [1:0]  mode_r;
  reg  [7:0]  pickup_r;
  reg  [7:0]  tms_r;
  reg  [19:0] min_dly_r;
  reg  [19:0] max_dly_r;
  reg  [19:0] cool_r;
  reg  [15:0] scale_r;
  reg  [1:0]  irq_stat_r;
  reg  [1:0]  irq_mask_r;

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  reg         blk_meta_r;
  reg         blk_sync_r;
  reg  [31:0] tick_cnt_r;
  reg         tick_r;
  reg  [15:0] flux_pct_r;
  reg  [19:0] elapsed_r;
  reg  [31:0] progress_r;
  reg  [19:0] cool_err_r;
  reg         start_prev_r;
  reg         trip_prev_r;

  wire        enabled;
  wire        clear_all;
  wire [31:0] flux_magnitude;
  wire        mag_valid;
  wire [47:0] pct_full;
  wire        start_status;
  wire        below_drop;
  wire [15:0] margin;
  wire [31:0] margin_sq;
  wire [15:0] inv_thr;
  wire        min_done;
  wire        max_done;
  wire        inv_done;
  wire        delay_expired;
  wire        trip_status;
  wire [1:0]  irq_events;
  wire [1:0]  irq_w1c;

  // ----------------------------------------------------------------
  // Block input synchroniser
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      blk_meta_r <= 1'b0;
      blk_sync_r <= 1'b0;
    end else begin
      blk_meta_r <= function_block_in_i;
      blk_sync_r <= blk_meta_r;
    end
  end

  // (RULE5) blocking disables
  // (RULE16) off or blocked clears all
  assign enabled   = ((mode_r == `OVPH_MODE_DEF) ||
                      (mode_r == `OVPH_MODE_INV)) && !blk_sync_r;
  assign clear_all = !enabled;

  // ----------------------------------------------------------------
  // Timebase: one enable pulse per 0.01 s
  // ----------------------------------------------------------------
  // (RULE17) fixed timebase tick
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 32'h0000_0001) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flux measurement
  // ----------------------------------------------------------------
  // (RULE1) integrate and find magnitude
  ovph_flux_calc #(
    .SW (SW),
    .FW (32)
  ) u_flux (
    .sys_clk_i        (sys_clk_i),
    .resetn_i         (resetn_i),
    .clear_i          (clear_all),
    .sample_valid_i   (sample_valid_i),
    .sample_i         (line_voltage_samples_i),
    .flux_magnitude_o (flux_magnitude),
    .mag_valid_o      (mag_valid)
  );

  // Scale holds 65536 * 100 % / rated magnitude, set by software
  assign pct_full = flux_magnitude * {16'h0000, scale_r};

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flux_pct_r <= 16'h0000;
    end else if (!mag_valid) begin
      flux_pct_r <= 16'h0000;
    end else if (|pct_full[47:32]) begin
      flux_pct_r <= 16'hffff;
    end else begin
      flux_pct_r <= pct_full[31:16];
    end
  end

  // ----------------------------------------------------------------
  // Characteristic
  // ----------------------------------------------------------------
  // (RULE12) start above pick-up
  assign start_status = enabled && mag_valid &&
                        (flux_pct_r > {8'h00, pickup_r});
  // (RULE14) drop-off below 95 %
  assign below_drop = ({flux_pct_r, 8'h00} * {16'h0000, `OVPH_DROP_DEN}) <
                      ({16'h0000, pickup_r, 8'h00} *
                       {24'h000000, `OVPH_DROP_NUM});

  assign margin    = flux_pct_r - {8'h00, pickup_r};
  assign margin_sq = margin * margin;
  // (RULE13) 0.18*TMS in tick units
  // (RULE8) multiplier used here only
  assign inv_thr   = {8'h00, tms_r} * {8'h00, `OVPH_INV_CONST};

  // (RULE9) minimum delay reached
  assign min_done = elapsed_r >= min_dly_r;
  // (RULE10) maximum delay cap
  assign max_done = elapsed_r >= max_dly_r;
  // (RULE13) integral of margin squared reached, clamped
  assign inv_done = (progress_r >= {16'h0000, inv_thr} && min_done) ||
                    max_done;

  // (RULE2) delay per mode
  assign delay_expired = (mode_r == `OVPH_MODE_INV) ? inv_done : min_done;

  // Elapsed time since pick-up; held in the hysteresis band
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      elapsed_r <= 20'h00000;
    // (RULE16) cleared when off or blocked
    end else if (clear_all || (below_drop && !start_status)) begin
      elapsed_r <= 20'h00000;
    end else if (tick_r && start_status && (elapsed_r != 20'hfffff)) begin
      elapsed_r <= elapsed_r + 20'h00001;
    end
  end

  // Inverse accumulator: adds margin squared per tick while started;
  // decays one unit per cool/thr ticks below drop-off, Bresenham style
  // so no divider is needed.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      progress_r <= 32'h0000_0000;
      cool_err_r <= 20'h00000;
    end else if (clear_all || (mode_r != `OVPH_MODE_INV)) begin
      progress_r <= 32'h0000_0000;
      cool_err_r <= 20'h00000;
    end else if (start_status) begin
      cool_err_r <= 20'h00000;
      if (tick_r) begin
        progress_r <= (progress_r + margin_sq < progress_r) ?
                      32'hffff_ffff : progress_r + margin_sq;
      end
    // (RULE14) linear decay
    // (RULE11) over cooling time
    end else if (below_drop && (progress_r != 32'h0000_0000)) begin
      if (progress_r > {16'h0000, inv_thr}) begin
        progress_r <= {16'h0000, inv_thr};
      end else if (cool_err_r >= cool_r) begin
        cool_err_r <= cool_err_r - cool_r;
        progress_r <= progress_r - 32'h0000_0001;
      end else if (tick_r) begin
        cool_err_r <= cool_err_r + {4'h0, inv_thr};
      end
    end
  end

  // ----------------------------------------------------------------
  // Decision logic and outputs
  // ----------------------------------------------------------------
  // (RULE3) start, expiry and block
  // (RULE15) trip only after delay
  assign trip_status = start_status && start_prev_r && delay_expired;

  // (RULE4) registered start and trip
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      general_start_out_o <= 1'b0;
      general_trip_out_o  <= 1'b0;
      start_prev_r        <= 1'b0;
      trip_prev_r         <= 1'b0;
    end else begin
      general_start_out_o <= start_status;
      general_trip_out_o  <= trip_status;
      start_prev_r        <= start_status;
      trip_prev_r         <= trip_status;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_events = {trip_status && !trip_prev_r,
                       start_status && !start_prev_r};
  assign irq_w1c    = (reg_wr_i && (reg_addr_i == `OVPH_REG_IRQ_STAT)) ?
                      reg_wdata_i[1:0] : 2'b00;
  assign irq_o      = |(irq_stat_r & irq_mask_r);

  // Set wins over a clear in the same cycle
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      irq_stat_r <= 2'b00;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_events;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // (RULE6) reset into definite time
  // (RULE7) pick-up default 110 %
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      mode_r     <= `OVPH_MODE_RST;
      pickup_r   <= `OVPH_PICKUP_RST;
      tms_r      <= `OVPH_TMS_RST;
      min_dly_r  <= `OVPH_MIN_DLY_RST;
      max_dly_r  <= `OVPH_MAX_DLY_RST;
      cool_r     <= `OVPH_COOL_RST;
      scale_r    <= `OVPH_SCALE_RST;
      irq_mask_r <= 2'b00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `OVPH_REG_CTRL: begin
          mode_r <= reg_wdata_i[1:0];
        end
        `OVPH_REG_PICKUP: begin
          pickup_r <= reg_wdata_i[7:0];
        end
        `OVPH_REG_TMS: begin
          tms_r <= reg_wdata_i[7:0];
        end
        `OVPH_REG_MIN_DLY: begin
          min_dly_r <= reg_wdata_i[19:0];
        end
        `OVPH_REG_MAX_DLY: begin
          max_dly_r <= reg_wdata_i[19:0];
        end
        `OVPH_REG_COOL: begin
          // Zero would decay one unit every clock; treat as one tick
          cool_r <= (reg_wdata_i[19:0] == 20'h00000) ? 20'h00001 :
                    reg_wdata_i[19:0];
        end
        `OVPH_REG_SCALE: begin
          scale_r <= reg_wdata_i[15:0];
        end
        `OVPH_REG_IRQ_MASK: begin
          irq_mask_r <= reg_wdata_i[1:0];
        end
        default: begin
          mode_r <= mode_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OVPH_REG_CTRL:     reg_rdata_o <= {30'h0, mode_r};
        `OVPH_REG_PICKUP:   reg_rdata_o <= {24'h0, pickup_r};
        `OVPH_REG_TMS:      reg_rdata_o <= {24'h0, tms_r};
        `OVPH_REG_MIN_DLY:  reg_rdata_o <= {12'h0, min_dly_r};
        `OVPH_REG_MAX_DLY:  reg_rdata_o <= {12'h0, max_dly_r};
        `OVPH_REG_COOL:     reg_rdata_o <= {12'h0, cool_r};
        `OVPH_REG_SCALE:    reg_rdata_o <= {16'h0, scale_r};
        `OVPH_REG_STATUS:   reg_rdata_o <= {28'h0, mag_valid, blk_sync_r,
                                            general_trip_out_o,
                                            general_start_out_o};
        `OVPH_REG_FLUX_PCT: reg_rdata_o <= {16'h0, flux_pct_r};
        `OVPH_REG_IRQ_STAT: reg_rdata_o <= {30'h0, irq_stat_r};
        `OVPH_REG_IRQ_MASK: reg_rdata_o <= {30'h0, irq_mask_r};
        default:            reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule // ovph_protect

`default_nettype wire

/* File: dv/ovph_front_end_model.sv */
// Voltage sampling front end: square-wave line voltage, one strobe
// every fourth clock. Assumes the block clock and its sync reset.
`timescale 1ns/10ps
`default_nettype none

module ovph_front_end_model (
  input  wire logic        sys_clk_i,      // Block clock
  input  wire logic        resetn_i,       // Sync reset, active low
  input  wire logic        enable_i,       // Produce samples
  input  wire logic [15:0] amp_i,          // Square-wave amplitude
  output logic             sample_valid_o, // One-cycle strobe
  output logic [15:0]      sample_o        // Signed sample
);
  // ----------------------------------------------------------------
  // Waveform
  // ----------------------------------------------------------------
  // Bit 6 flips every 16 samples; the flux becomes a clean triangle
  logic [6:0]  phase_r;
  logic [15:0] level;
  logic        fire;

  assign level = phase_r[6] ? (~amp_i + 16'h0001) : amp_i;
  assign fire  = enable_i && (phase_r[1:0] == 2'h3);

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      phase_r        <= 7'h00;
      sample_valid_o <= 1'b0;
      sample_o       <= 16'h0000;
    end else begin
      phase_r        <= phase_r + 7'h01;
      sample_valid_o <= fire;
      // Junk between strobes so a stale value is never mistaken
      sample_o       <= fire ? level : ~sample_o;
    end
  end
endmodule // ovph_front_end_model

`default_nettype wire

/* File: dv/ovph_protect_checker.sv */
// Port-level assertions for the overflux protection block.
// Assumes single clock domain, sync active-low reset; bound below.
`timescale 1ns/10ps
`default_nettype none

module ovph_protect_checker (
  input wire          sys_clk_i,            // Block clock
  input wire          resetn_i,             // Sync reset, active low
  input wire          sample_valid_i,       // Sample strobe
  input wire          function_block_in_i,  // User block
  input wire [7:0]    reg_addr_i,           // Register address
  input wire          reg_wr_i,             // Write strobe
  input wire          reg_rd_i,             // Read strobe
  input wire [31:0]   reg_rdata_o,          // Read data
  input wire          general_start_out_o,  // Start warning
  input wire          general_trip_out_o,   // Trip command
  input wire          irq_o                 // Level interrupt
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Sync chain plus output register gives the blocking latency
  property p_block_start;
    function_block_in_i [*5] |-> !general_start_out_o;
  endproperty
  a_block_start: assert property (p_block_start)
    else $error("start seen while blocked");

  property p_block_trip;
    function_block_in_i [*5] |-> !general_trip_out_o;
  endproperty
  a_block_trip: assert property (p_block_trip)
    else $error("trip seen while blocked");

  property p_start_first;
    $rose(general_trip_out_o) |-> general_start_out_o &&
      $past(general_start_out_o);
  endproperty
  a_start_first: assert property (p_start_first)
    else $error("trip rose without prior start");

  property p_trip_needs_start;
    general_trip_out_o |-> $past(general_start_out_o);
  endproperty
  a_trip_needs_start: assert property (p_trip_needs_start)
    else $error("trip without start");

  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");

  property p_unmapped;
    reg_rd_i && reg_addr_i == 8'h2c |=> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_irq_fall;
    $fell(irq_o) |-> $past(reg_wr_i);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without a write");

  // A fresh start follows a strobed sample or a setting write
  property p_start_cause;
    $rose(general_start_out_o) |-> $past(sample_valid_i, 2) ||
      $past(sample_valid_i, 3) || $past(sample_valid_i, 4) ||
      $past(reg_wr_i, 2) || $past(reg_wr_i, 3);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start rose with no sample");
endmodule // ovph_protect_checker

bind ovph_protect ovph_protect_checker ovph_protect_checker_i (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .sample_valid_i(sample_valid_i),
  .function_block_in_i(function_block_in_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .general_start_out_o(general_start_out_o),
  .general_trip_out_o(general_trip_out_o), .irq_o(irq_o)
);

`default_nettype wire

/* File: dv/ovph_protect_bench.sv */
// Self-checking bench for the overflux protection block.
// Assumes the front-end model and a short timebase tick.
`timescale 1ns/10ps
`default_nettype none
`include "ovph_defines.vh"

module ovph_protect_bench;
  localparam int TICK = 50;               // Clocks per tick here
  logic        sys_clk_i;
  logic        resetn_i;
  logic        fe_en;
  logic [15:0] fe_amp;
  logic        block_in;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  wire logic        sample_valid;
  wire logic [15:0] sample;
  wire logic [31:0] reg_rdata;
  wire logic        start_out;
  wire logic        trip_out;
  wire logic        irq;
  int          errors;
  int          total_checks;
  // Amplitudes give about 120 % and 100 % at unity scale
  localparam logic [15:0] HI = 16'h0f00;
  localparam logic [15:0] LO = 16'h0c80;

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  ovph_front_end_model ovph_front_end_model_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .enable_i(fe_en),
    .amp_i(fe_amp), .sample_valid_o(sample_valid), .sample_o(sample));

  ovph_protect #(.SW(16), .TICK_CYCLES(TICK)) ovph_protect_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .sample_valid_i(sample_valid), .line_voltage_samples_i(sample),
    .function_block_in_i(block_in), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .general_start_out_o(start_out),
    .general_trip_out_o(trip_out), .irq_o(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // Cycles until an output is high; a required one that never comes ends
  task automatic wait_out(input bit trip, input int max, input bit must,
                          output int n);
    n = 0;
    while (n < max && ((trip ? trip_out : start_out) !== 1'b1)) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    if (must && n >= max) begin
      check(1'b0, 1'b1);
      stop_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(`OVPH_REG_CTRL, 32'h1);
    rd_chk(`OVPH_REG_PICKUP, 32'h6e);
    rd_chk(`OVPH_REG_TMS, 32'ha);
    rd_chk(`OVPH_REG_MIN_DLY, 32'h3e8);
    rd_chk(`OVPH_REG_MAX_DLY, 32'h493e0);
    rd_chk(`OVPH_REG_COOL, 32'h186a0);
    rd_chk(`OVPH_REG_IRQ_MASK, 32'h0);
    rd_chk(8'h2c, 32'h0);
  endtask

  task automatic t_definite;
    int n;
    wr(`OVPH_REG_MIN_DLY, 32'h14);
    wr(`OVPH_REG_IRQ_MASK, 32'h3);
    fe_amp <= HI;
    fe_en  <= 1'b1;
    wait_out(0, 2000, 1, n);
    check(trip_out, 1'b0);
    wait_out(1, 1500, 1, n);
    check(n >= 18 * TICK && n <= 22 * TICK, 1'b1);
    check(irq, 1'b1);
    rd_chk(`OVPH_REG_STATUS, 32'hb);
    rd_chk(`OVPH_REG_IRQ_STAT, 32'h3);
    wr(`OVPH_REG_IRQ_STAT, 32'h3);
    #1 check(irq, 1'b0);
  endtask

  task automatic t_block;
    int n;
    @(posedge sys_clk_i);
    block_in <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1 check(start_out, 1'b0);
    check(trip_out, 1'b0);
    rd_chk(`OVPH_REG_STATUS, 32'h4);
    @(posedge sys_clk_i);
    block_in <= 1'b0;
    wait_out(0, 2000, 1, n);
    check(trip_out, 1'b0);
  endtask

  task automatic t_quiet;
    int n;
    wr(`OVPH_REG_CTRL, 32'h0);
    repeat (4) @(posedge sys_clk_i);
    wait_out(0, 600, 0, n);
    check(n == 600, 1'b1);
    fe_amp <= LO;
    wr(`OVPH_REG_CTRL, 32'h1);
    wait_out(0, 800, 0, n);
    check(n == 800, 1'b1);
  endtask

  task automatic t_inverse;
    int n;
    wr(`OVPH_REG_TMS, 32'h32);
    wr(`OVPH_REG_MIN_DLY, 32'h2);
    wr(`OVPH_REG_CTRL, 32'h2);
    fe_amp <= HI;
    wait_out(0, 2000, 1, n);
    wait_out(1, 1000, 1, n);
    check(n >= 5 * TICK && n <= 14 * TICK, 1'b1);
    // Short cooling so the next run starts from no progress
    wr(`OVPH_REG_COOL, 32'h1);
    fe_amp <= LO;
    repeat (1400) @(posedge sys_clk_i);
    #1 check(start_out, 1'b0);
    wr(`OVPH_REG_TMS, 32'h64);
    wr(`OVPH_REG_MAX_DLY, 32'h4);
    fe_amp <= HI;
    wait_out(0, 2000, 1, n);
    wait_out(1, 1000, 1, n);
    check(n <= 7 * TICK, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors       = 0;
    total_checks = 0;
    resetn_i     = 1'b0;
    fe_en        = 1'b0;
    fe_amp       = 16'h0000;
    block_in     = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 32'h0000_0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_definite();
    t_block();
    t_quiet();
    t_inverse();
    stop_test();
  end
endmodule // ovph_protect_bench

`default_nettype wire
